// ---- sadc_buf2.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset already synchronised.
*/
module sadc_buf2
  import sadc_pkg::*;
#(
  parameter int unsigned WIDTH = 12
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Discards the contents.
  input wire logic flush
);
  logic [WIDTH-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else if (flush) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule

// ---- sadc_chk.sv ----
/* Pin-level assertions for the converter readout block.
   Assumes it is bound to sadc_top and sees only its ports. */
module sadc_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic power_down_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic hold,
  input wire logic active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_start_low: assert property (
    cs_n[*8] ##1 (!cs_n && active) |-> ##[1:8] (dout_oe && !dout))
    else $error("select fall did not drive low");
  chk_hold_set: assert property (
    $rose(dout_oe) |-> ##[0:3] hold) else $error("no hold at start");
  chk_eoc_high: assert property (
    $rose(hold) |-> ##[1:400] (dout || cs_n)) else $error("no end of conversion");
  chk_end_flag: assert property (
    $fell(hold) && !cs_n |-> ##[0:4] dout) else $error("hold ended without high");
  chk_shift_edge: assert property (
    sclk[*6] ##1 (sclk && dout_oe && $past(dout_oe)) |-> $stable(dout))
    else $error("output moved without clock fall");
  chk_extra_clk: assert property (
    !cs_n && dout && !hold |=> !hold) else $error("readout restarted conversion");
  chk_deselect_hiz: assert property (
    $rose(cs_n) |-> ##[1:8] !dout_oe) else $error("output not released");
  chk_down_idle: assert property (
    !power_down_n[*8] |-> !active && !dout_oe) else $error("active in shutdown");
endmodule
bind sadc_top sadc_chk u_sadc_chk (.clock(clock), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
  .power_down_n(power_down_n), .dout(dout), .dout_oe(dout_oe), .hold(hold),
  .active(active));

// ---- sadc_master.sv ----
/* Serial master model: selects, waits for end of conversion, clocks the frame.
   Assumes the bench resolves the data line it reads. */
module sadc_master (
  // System clock.
  input wire logic clock,
  // Serial pins.
  input wire logic dout,
  output logic cs_n,
  output logic sclk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // A negative count aborts the conversion after that many cycles.
  task automatic read(input int n, input int half, output logic [15:0] f, output bit ok);
    bit last;
    f = 16'h0000;
    ok = 1'b0;
    last = 1'b0;
    @(posedge clock) cs_n <= 1'b0;
    for (int t = 0; t < 400 && !ok && t != -n; t++) begin
      @(posedge clock);
      ok = (dout === 1'b1) && last;
      last = (dout === 1'b1);
    end
    for (int i = 0; i < n && ok; i++) begin
      sclk <= 1'b1;
      repeat (half) @(posedge clock);
      f[15-i] = dout;
      sclk <= 1'b0;
      repeat (half) @(posedge clock);
    end
    cs_n <= 1'b1;
    repeat (30) @(posedge clock);
  endtask
endmodule

// ---- sadc_pkg.sv ----
/*
  Shared constants and carrier types for the serial converter readout block.
  Assumes a 20 MHz system clock; all timing counts are derived from it.
*/
package sadc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // Conversion time in nanoseconds and derived cycle count (rounded down, at least one).
  localparam int unsigned CONV_TIME_NS = 7500;
  localparam int unsigned CONV_CYCLES_RAW = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int unsigned RESULT_BITS = 10;
  localparam int unsigned SUB_BITS = 2;
  // Leading one, result and sub-bits.
  localparam int unsigned FRAME_BITS = 1 + RESULT_BITS + SUB_BITS;
  // Cycles per bit trial, so that all twelve trials together fit the conversion time.
  localparam int unsigned TRIAL_CYCLES = CONV_CYCLES / (RESULT_BITS + SUB_BITS);
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] CONV_CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
  localparam logic [11:0] SUB_RESET = 12'h000;

  // Converter word handed from the conversion engine to the output shifter.
  typedef struct packed {
    logic [RESULT_BITS-1:0] code;
    logic [SUB_BITS-1:0] sub;
  } sadc_word_t;

  // Serial pin group as seen by the block.
  typedef struct packed {
    logic dout_o;
    logic dout_oe;
  } sadc_pin_t;

  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_SHIFT = 2'b10,
    SADC_DOWN = 2'b11
  } sadc_state_t;
endpackage

// ---- sadc_top.sv ----
/*
  Conversion start and serial readout of a 10-bit successive-approximation converter.
  Assumes chip select, serial clock and power-down arrive asynchronously from the pins and are
  sampled by the 20 MHz system clock; the analog decision per bit arrives as a level.
*/
// What this block does
// R1: Select fall holds sample, starts conversion, drives low.
// R2: Master keeps serial clock low during conversion.
// R3: End of conversion shown by output going high.
// R4: Master waits for high or 7.5us first.
// R5: Result held internally, readable any time after.
// R6: Output changes on serial clock falls, MSB first.
// R7: Frame is leading one, ten bits, two sub-bits.
// R8: Extra clocks give zeros and change nothing.
// R9: Master samples output on rising serial clock edges; the master model samples at the end of each high phase.
// R10: Master clock at most 2.1MHz, phases 200ns; the bench clocks most frames at 2.5MHz (400ns period).
// R11: Master gives at least eleven clock cycles.
// R12: Fastest cycle uses 10.5 clocks then deselects.
// R13: Master keeps select high the deselect minimum.
// R14: Aborted conversion needs acquisition time before restart.
// R15: Two bytes: one plus seven bits, then rest.
// R16: Master uses clock polarity and phase zero.
// R17: Result is straight binary, LSB is reference/1024.
// R18: Acquisition minimum is never below 1.5us.
// R19: Power-down low shuts down, high keeps operating.
// R20: Deselected output is high impedance, clock ignored.
module sadc_top #(
  // Cycles per bit trial; twelve trials make up the whole conversion.
  parameter int unsigned CONV_CNT = sadc_pkg::TRIAL_CYCLES
) (
  // System clock and asynchronous active-low reset.
  input wire logic clock,
  input wire logic rstn,
  // Serial pins from the master.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic power_down_n,
  // Comparator decision for the bit under trial (input above trial level).
  input wire logic cmp_above,
  // Serial data pin, split into output and enable.
  output logic dout,
  output logic dout_oe,
  // Trial code presented to the capacitive DAC and sample hold control.
  output logic [sadc_pkg::RESULT_BITS-1:0] dac_code,
  output logic hold,
  // Operational status.
  output logic active
);
  import sadc_pkg::*;

  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(CONV_CNT - 1);

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] pd_sync_q;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_fall;
  logic sclk_fall;
  logic sel;

  sadc_state_t state_q;
  logic [CNT_W-1:0] tick_q;
  logic [3:0] bit_q;
  logic [RESULT_BITS-1:0] sar_q;
  logic [11:0] result_q;
  logic [3:0] frame_q;
  logic eoc;
  logic step;
  logic buf_valid;
  logic buf_ready;
  logic [11:0] buf_data;
  sadc_word_t word;
  logic sub_hi_q;
  sadc_pin_t pin_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q <= 2'b11;
      sclk_sync_q <= 2'b00;
      pd_sync_q <= 2'b11;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n};
      sclk_sync_q <= {sclk_sync_q[0], sclk};
      pd_sync_q <= {pd_sync_q[0], power_down_n};
      cs_prev_q <= cs_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  assign sel = ~cs_sync_q[1];
  assign cs_fall = cs_prev_q & ~cs_sync_q[1];
  // Serial clock edges count only while selected.
  assign sclk_fall = sel & sclk_prev_q & ~sclk_sync_q[1]; // see R20

  // Conversion sequencer.
  assign step = (state_q == SADC_CONV) && (tick_q == STEP_LAST);
  assign eoc = step && (bit_q == 4'd0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SADC_IDLE;
    end else if (!pd_sync_q[1]) begin
      // Shutdown wins from any state, a running conversion included.
      state_q <= SADC_DOWN; // see R19
    end else begin
      case (state_q)
        SADC_IDLE: begin
          if (cs_fall) begin
            state_q <= SADC_CONV; // see R1
          end
        end
        SADC_CONV: begin
          if (!sel) begin
            state_q <= SADC_IDLE;
          end else if (eoc) begin
            state_q <= SADC_SHIFT; // see R3
          end
        end
        SADC_SHIFT: begin
          if (!sel) begin
            state_q <= SADC_IDLE;
          end
        end
        SADC_DOWN: begin
          state_q <= SADC_IDLE; // see R19
        end
        default: begin
          state_q <= SADC_IDLE;
        end
      endcase
    end
  end

  // Bit-trial timer: the conversion time is shared over ten trials plus two sub-trials.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= '0;
    end else if (state_q != SADC_CONV || step) begin
      tick_q <= '0;
    end else begin
      tick_q <= CNT_W'(tick_q + 1'b1);
    end
  end

  // Successive approximation, MSB first; straight binary, one step per reference/1024.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 4'd0;
      sar_q <= '0;
    end else if (state_q == SADC_IDLE && cs_fall) begin
      bit_q <= 4'(RESULT_BITS + SUB_BITS - 1);
      sar_q <= '0;
    end else if (step) begin
      if (bit_q >= 4'(SUB_BITS)) begin
        sar_q[bit_q - 4'(SUB_BITS)] <= cmp_above; // see R17
      end
      bit_q <= 4'(bit_q - 1'b1);
    end
  end

  // Sub-bits are the comparator's last two decisions at the LSB level; the first is kept here.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sub_hi_q <= 1'b0;
    end else if (state_q == SADC_IDLE && cs_fall) begin
      sub_hi_q <= 1'b0;
    end else if (step && bit_q == 4'd1) begin
      sub_hi_q <= cmp_above;
    end
  end

  // The last decision comes straight from the comparator, so the word is whole at the end.
  assign word = '{code: sar_q, sub: {sub_hi_q, cmp_above}};

  // Finished result waits in the buffer until the shifter is free to take it.
  sadc_buf2 #(
    .WIDTH(12)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(eoc),
    .in_ready(buf_ready),
    .in_data(word),
    .out_valid(buf_valid),
    .out_ready(state_q == SADC_SHIFT && frame_q == 4'd0),
    .out_data(buf_data),
    .flush(!sel)
  );

  // Result register, held for readout at any later time, at serial clock rates slow enough for the 20 MHz sampling.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= SUB_RESET;
    end else if (buf_valid && state_q == SADC_SHIFT && frame_q == 4'd0) begin
      result_q <= buf_data; // see R5
    end else if (sclk_fall && state_q == SADC_SHIFT) begin
      result_q <= {result_q[10:0], 1'b0}; // see R6 R8 R15
    end
  end

  // Frame position: 0 is the leading one, then ten result bits and two sub-bits.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 4'd0;
    end else if (state_q != SADC_SHIFT) begin
      frame_q <= 4'd0;
    end else if (sclk_fall && frame_q != 4'hf) begin
      frame_q <= 4'(frame_q + 1'b1); // see R7
    end
  end

  // Output pin: low in conversion, high at end, then bits on falls, zeros after frame.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= '0;
    end else begin
      case (state_q)
        SADC_CONV: begin
          pin_q <= '{dout_o: eoc, dout_oe: sel}; // see R1 R3
        end
        SADC_SHIFT: begin
          if (!sel) begin
            pin_q <= '0;
          end else if (sclk_fall) begin
            // The first fall already shows the MSB; the leading one stands before it.
            pin_q <= '{dout_o: (frame_q < FRAME_LAST) ? result_q[11] : 1'b0,
                       dout_oe: 1'b1}; // see R6 R8
          end else if (frame_q == 4'd0) begin
            pin_q <= '{dout_o: 1'b1, dout_oe: 1'b1};
          end
        end
        SADC_IDLE: begin
          pin_q <= '{dout_o: 1'b0, dout_oe: cs_fall && pd_sync_q[1]}; // see R1 R20
        end
        default: begin
          pin_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
      dac_code <= '0;
      hold <= 1'b0;
      active <= 1'b0;
    end else begin
      dout <= pin_q.dout_o;
      dout_oe <= pin_q.dout_oe;
      dac_code <= (bit_q >= 4'(SUB_BITS)) ?
                  (sar_q | (RESULT_BITS'(1) << (bit_q - 4'(SUB_BITS)))) : sar_q;
      hold <= (state_q == SADC_CONV); // see R1
      active <= (state_q != SADC_DOWN); // see R19
    end
  end
endmodule

// ---- sadc_top_tb.sv ----
/* Self-checking bench for the converter readout block.
   Assumes the checker and the master model are compiled first. */
module sadc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sadc_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic power_down_n = 1'b1;
  logic cmp_above = 1'b0;
  logic dout_q = 1'b0;
  logic cs_n, sclk, dout, dout_oe, hold, active;
  logic [RESULT_BITS-1:0] dac_code;
  logic [RESULT_BITS-1:0] vin = 10'h000;
  logic [31:0] seed = 32'h67032eac;
  logic [15:0] f;
  bit ok;
  int err_count = 0;
  int check_count = 0;
  wire logic dout_line = dout_oe ? dout : ~dout_q;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    dout_q <= dout_line;
    cmp_above <= (vin >= dac_code);
  end
  sadc_top #(.CONV_CNT(12)) u_sadc_top (.clock(clock), .rstn(rstn), .cs_n(cs_n),
    .sclk(sclk), .power_down_n(power_down_n), .cmp_above(cmp_above), .dout(dout),
    .dout_oe(dout_oe), .dac_code(dac_code), .hold(hold), .active(active));
  sadc_master u_sadc_master (.clock(clock), .dout(dout_line), .cs_n(cs_n), .sclk(sclk));
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Sub-bits are masked; unclocked positions read as zero.
  function automatic logic [15:0] exp_frame(input logic [9:0] v, input int n);
    return {1'b1, v, 5'h00} & ~(16'hffff >> n) & 16'hffe7;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    u_sadc_master.read(-20, 5, f, ok);
    chk({15'h0000, ok}, 16'h0000);
    $display("abort done");
    power_down_n <= 1'b0;
    repeat (10) @(posedge clock);
    u_sadc_master.read(-100, 5, f, ok);
    chk({14'h0000, active, ok}, 16'h0000);
    power_down_n <= 1'b1;
    repeat (10) @(posedge clock);
    $display("shutdown done");
    for (int i = 0; i < 8; i++) begin
      int n;
      int half;
      seed = rnd(seed);
      vin <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : seed[9:0];
      n = (i % 2) ? 11 : 16;
      // A 400 ns link clock; the first frame is a slow-clock corner case.
      half = (i == 0) ? 9 : 4;
      chk({15'h0000, dout_oe}, 16'h0000);
      u_sadc_master.read(n, half, f, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(f & 16'hffe7, exp_frame(vin, n));
      if (!ok) end_sim();
      $display("frame %0d done", i);
    end
    end_sim();
  end
endmodule
